// File: afc_pkg.sv
/*
 * Package for the front-end configuration register bank: register indices, field
 * positions, reset values, field encodings and the bundled decode structures.
 * Assumes an AXI4-Lite master with 32-bit data; each register takes one aligned word.
 */
package afc_pkg;
    // -------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [4:0] IDX_GLOBAL = 5'h01;
    localparam logic [4:0] IDX_TEST = 5'h02;
    localparam logic [4:0] IDX_REF = 5'h03;
    localparam logic [4:0] IDX_FAULT = 5'h04;
    localparam logic [4:0] IDX_CH_FIRST = 5'h05;
    localparam logic [4:0] IDX_CH_LAST = 5'h0C;
    localparam int NUM_CH = 8;
    localparam int ADDR_LSB = 2;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_GLOBAL = 8'h91;
    localparam logic [7:0] RST_TEST = 8'hE0;
    localparam logic [7:0] RST_REF = 8'h40;
    localparam logic [7:0] RST_FAULT = 8'h00;
    localparam logic [7:0] RST_CH = 8'h10;

    // -------------------------------------------------------------------
    // Fixed bits: value forced and mask of bits held by hardware
    // -------------------------------------------------------------------
    localparam logic [7:0] FIX_MASK_GLOBAL = 8'h98;
    localparam logic [7:0] FIX_VAL_GLOBAL = 8'h90;
    localparam logic [7:0] FIX_MASK_TEST = 8'hE8;
    localparam logic [7:0] FIX_VAL_TEST = 8'hE0;
    localparam logic [7:0] FIX_MASK_REF = 8'h53;
    localparam logic [7:0] FIX_VAL_REF = 8'h40;
    localparam logic [7:0] FIX_MASK_FAULT = 8'h1F;
    localparam logic [7:0] FIX_MASK_CH = 8'h08;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int B_READBACK = 6;
    localparam int B_CLK_OUT = 5;
    localparam int B_INT_TEST = 4;
    localparam int B_TEST_AMP = 2;
    localparam int B_REFBUF = 7;
    localparam int B_REF_HIGH = 5;
    localparam int B_AMP_ROUTE = 3;
    localparam int B_AMP_ON = 2;
    localparam int B_CH_PD = 7;

    // -------------------------------------------------------------------
    // Encodings
    // -------------------------------------------------------------------
    localparam logic [2:0] RATE_ILLEGAL = 3'h7;
    localparam logic [2:0] RATE_32K = 3'h1;
    localparam logic [2:0] RATE_64K = 3'h0;
    localparam logic [1:0] TFREQ_UNUSED = 2'h2;
    localparam logic [1:0] TFREQ_DC = 2'h3;
    localparam logic [1:0] TFREQ_DIV20 = 2'h1;
    localparam int TEST_DIV21_LOG = 21;
    localparam int TEST_DIV20_LOG = 20;
    localparam logic [2:0] GAIN_1 = 3'h1;
    localparam logic [2:0] INSEL_NORMAL = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic readback_multi;
        logic clk_out_en;
        logic [2:0] rate_field;
        logic rate_24bit;
        logic int_test;
        logic test_amp_x2;
        logic [1:0] test_frequency_sel;
        logic ref_buffer_on;
        logic ref_level_high;
        logic amp_input_route;
        logic amp_power_on;
        logic [2:0] comparator_threshold_sel;
    } afc_global_t;

    typedef struct packed {
        logic channel_power_down;
        logic [2:0] channel_gain_sel;
        logic [2:0] channel_input_sel;
    } afc_chan_t;
endpackage

// File: afc_regbank.sv
/*
 * AXI4-Lite register bank for the converter front-end configuration.
 * Assumes a single clock, an AXI4-Lite master keeping the usual valid/ready
 * rules, and a clock-select pin from outside that is synchronised here.
 */
module afc_regbank #(
    parameter int NCH = afc_pkg::NUM_CH
) (
    input wire logic sys_clk, // 10 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    input wire logic clock_source_pin, // Clock-select pin, asynchronous
    output afc_pkg::afc_global_t cfg_global, // Decoded global settings
    output afc_pkg::afc_chan_t [NCH-1:0] cfg_chan, // Decoded channel settings
    output logic osc_clk_out_en, // Oscillator drives clock pin
    output logic test_pulse, // Internal test signal level
    output logic cfg_illegal // An illegal code is programmed
);
    // -------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------
    logic [7:0] glob_q, test_q, ref_q, fault_q;
    logic [7:0] ch_q [NCH];

    // -------------------------------------------------------------------
    // Write channel: address and data taken in either order
    // -------------------------------------------------------------------
    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [4:0] widx;

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign widx = awaddr_q[afc_pkg::ADDR_LSB +: 5];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // Ready registered so it also comes from a flip-flop; one transaction at a time
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid
                             && !do_write;
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid
                            && !do_write;
        end
    end

    function automatic logic idx_mapped(input logic [4:0] idx);
        idx_mapped = (idx >= afc_pkg::IDX_GLOBAL) && (idx <= afc_pkg::IDX_CH_LAST);
    endfunction

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= afc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= idx_mapped(widx) && (awaddr_q[1:0] == 2'h0)
                           ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Register update; only lane 0 holds data, fixed bits are forced
    // -------------------------------------------------------------------
    logic wr_en;
    logic [7:0] wbyte;
    assign wr_en = do_write && wstrb_q[0] && (awaddr_q[1:0] == 2'h0);
    assign wbyte = wdata_q[7:0];

    // Fixed bits are held by hardware, so a careless host write cannot corrupt them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            glob_q <= afc_pkg::RST_GLOBAL;
        end else if (wr_en && widx == afc_pkg::IDX_GLOBAL) begin
            glob_q <= (wbyte & ~afc_pkg::FIX_MASK_GLOBAL) | afc_pkg::FIX_VAL_GLOBAL;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            test_q <= afc_pkg::RST_TEST;
        end else if (wr_en && widx == afc_pkg::IDX_TEST) begin
            test_q <= (wbyte & ~afc_pkg::FIX_MASK_TEST) | afc_pkg::FIX_VAL_TEST;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_q <= afc_pkg::RST_REF;
        end else if (wr_en && widx == afc_pkg::IDX_REF) begin
            ref_q <= (wbyte & ~afc_pkg::FIX_MASK_REF) | afc_pkg::FIX_VAL_REF;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fault_q <= afc_pkg::RST_FAULT;
        end else if (wr_en && widx == afc_pkg::IDX_FAULT) begin
            fault_q <= wbyte & ~afc_pkg::FIX_MASK_FAULT;
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                ch_q[g] <= afc_pkg::RST_CH;
            end else if (wr_en && widx == afc_pkg::IDX_CH_FIRST + 5'(g)) begin
                ch_q[g] <= wbyte & ~afc_pkg::FIX_MASK_CH;
            end
        end
    end

    // -------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------
    logic [7:0] rbyte;
    logic [4:0] ridx;
    logic ralign;
    assign ridx = s_axi_araddr[afc_pkg::ADDR_LSB +: 5];
    // Misaligned reads return zero data alongside the error response
    assign ralign = (s_axi_araddr[1:0] == 2'h0);

    always_comb begin
        rbyte = 8'h00;
        if (ridx == afc_pkg::IDX_GLOBAL) rbyte = glob_q;
        else if (ridx == afc_pkg::IDX_TEST) rbyte = test_q;
        else if (ridx == afc_pkg::IDX_REF) rbyte = ref_q;
        else if (ridx == afc_pkg::IDX_FAULT) rbyte = fault_q;
        else begin
            for (int i = 0; i < NCH; i++) begin
                if (ridx == afc_pkg::IDX_CH_FIRST + 5'(i)) rbyte = ch_q[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= afc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, ralign ? rbyte : 8'h00};
            s_axi_rresp <= idx_mapped(ridx) && ralign
                           ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Clock-select pin synchroniser and oscillator output gate
    // -------------------------------------------------------------------
    logic clock_source_pin_m_q, clock_source_pin_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clock_source_pin_m_q <= 1'b0;
            clock_source_pin_q <= 1'b0;
        end else begin
            clock_source_pin_m_q <= clock_source_pin;
            clock_source_pin_q <= clock_source_pin_m_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            osc_clk_out_en <= 1'b0;
        end else begin
            osc_clk_out_en <= clock_source_pin_q && glob_q[afc_pkg::B_CLK_OUT];
        end
    end

    // -------------------------------------------------------------------
    // Decoded settings
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_global <= '0;
            cfg_global.rate_field <= afc_pkg::RATE_32K;
            cfg_chan <= '0;
            for (int i = 0; i < NCH; i++) begin
                cfg_chan[i].channel_gain_sel <= afc_pkg::GAIN_1;
            end
        end else begin
            cfg_global.readback_multi <= glob_q[afc_pkg::B_READBACK];
            cfg_global.clk_out_en <= glob_q[afc_pkg::B_CLK_OUT];
            cfg_global.rate_field <= glob_q[2:0];
            cfg_global.rate_24bit <= (glob_q[2:0] != afc_pkg::RATE_64K)
                                     && (glob_q[2:0] != afc_pkg::RATE_32K);
            cfg_global.int_test <= test_q[afc_pkg::B_INT_TEST];
            cfg_global.test_amp_x2 <= test_q[afc_pkg::B_TEST_AMP];
            cfg_global.test_frequency_sel <= test_q[1:0];
            cfg_global.ref_buffer_on <= ref_q[afc_pkg::B_REFBUF];
            cfg_global.ref_level_high <= ref_q[afc_pkg::B_REF_HIGH];
            cfg_global.amp_input_route <= ref_q[afc_pkg::B_AMP_ROUTE];
            cfg_global.amp_power_on <= ref_q[afc_pkg::B_AMP_ON];
            cfg_global.comparator_threshold_sel <= fault_q[7:5];
            for (int i = 0; i < NCH; i++) begin
                cfg_chan[i].channel_power_down <= ch_q[i][afc_pkg::B_CH_PD];
                cfg_chan[i].channel_gain_sel <= ch_q[i][6:4];
                cfg_chan[i].channel_input_sel <= ch_q[i][2:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // Illegal code detection, flagged rather than corrected
    // -------------------------------------------------------------------
    function automatic logic gain_bad(input logic [2:0] g);
        gain_bad = (g == 3'h0) || (g == 3'h3) || (g == 3'h7);
    endfunction
    function automatic logic insel_bad(input logic [2:0] m);
        insel_bad = (m == 3'h2) || (m == 3'h6) || (m == 3'h7);
    endfunction

    logic illegal_d;
    always_comb begin
        illegal_d = (glob_q[2:0] == afc_pkg::RATE_ILLEGAL)
                    || (test_q[1:0] == afc_pkg::TFREQ_UNUSED);
        for (int i = 0; i < NCH; i++) begin
            illegal_d = illegal_d || gain_bad(ch_q[i][6:4])
                        || insel_bad(ch_q[i][2:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_illegal <= 1'b0;
        end else begin
            cfg_illegal <= illegal_d;
        end
    end

    // -------------------------------------------------------------------
    // Internal test signal: square wave at clk/2^21 or clk/2^20, or dc
    // -------------------------------------------------------------------
    logic [afc_pkg::TEST_DIV21_LOG-1:0] tdiv_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tdiv_q <= '0;
        end else begin
            tdiv_q <= tdiv_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            test_pulse <= 1'b0;
        end else if (!test_q[afc_pkg::B_INT_TEST]) begin
            test_pulse <= 1'b0;
        end else if (test_q[1:0] == afc_pkg::TFREQ_DC) begin
            test_pulse <= 1'b1;
        end else if (test_q[1:0] == afc_pkg::TFREQ_DIV20) begin
            test_pulse <= tdiv_q[afc_pkg::TEST_DIV20_LOG-1];
        end else begin
            test_pulse <= tdiv_q[afc_pkg::TEST_DIV21_LOG-1];
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_ref_fixed_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
        ref_q[6] && !ref_q[4] && (ref_q[1:0] == 2'h0)) else $error("fixed ref bits wrong");
    a_glob_fixed: assert property (@(posedge sys_clk) disable iff (!rstn)
        (glob_q & afc_pkg::FIX_MASK_GLOBAL) == afc_pkg::FIX_VAL_GLOBAL)
        else $error("global fixed bits wrong");
    a_test_fixed: assert property (@(posedge sys_clk) disable iff (!rstn)
        (test_q & afc_pkg::FIX_MASK_TEST) == afc_pkg::FIX_VAL_TEST)
        else $error("test fixed bits wrong");
    a_fault_low_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        (fault_q & afc_pkg::FIX_MASK_FAULT) == 8'h00) else $error("fault low bits set");
    a_ch_bit3_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        ch_q[0][3] == 1'b0) else $error("channel bit 3 set");
    a_clkout_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        osc_clk_out_en |-> $past(clock_source_pin_q) && $past(glob_q[afc_pkg::B_CLK_OUT]))
        else $error("clock out without select");
    a_readback_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
        $changed(glob_q[afc_pkg::B_READBACK]) |=> cfg_global.readback_multi ==
        $past(glob_q[afc_pkg::B_READBACK])) else $error("readback mode decode");
    a_write_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_en && widx == afc_pkg::IDX_FAULT) |=> fault_q == ($past(wbyte) & 8'hE0))
        else $error("fault write not stored");
    a_read_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("read not answered");
    a_test_dc: assert property (@(posedge sys_clk) disable iff (!rstn)
        (test_q[4] && test_q[1:0] == afc_pkg::TFREQ_DC) [*2] |-> test_pulse)
        else $error("dc test level missing");
    a_ext_test_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        !test_q[4] [*2] |-> !test_pulse) else $error("test pulse while external");

    c_write_done: cover property (@(posedge sys_clk) disable iff (!rstn)
        s_axi_bvalid && s_axi_bready && s_axi_bresp == afc_pkg::RESP_OKAY);
    c_read_done: cover property (@(posedge sys_clk) disable iff (!rstn)
        s_axi_rvalid && s_axi_rready);
    c_clk_out: cover property (@(posedge sys_clk) disable iff (!rstn) osc_clk_out_en);
    c_illegal: cover property (@(posedge sys_clk) disable iff (!rstn) cfg_illegal);
endmodule

// File: afc_host.sv
/* AXI4-Lite host model that configures the register bank.
   Assumes the bench calls wr and rd one at a time, after reset is released. */
module afc_host (
    input wire logic sys_clk, // Clock
    output logic [7:0] s_axi_awaddr, // Write address
    output logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    output logic [31:0] s_axi_wdata, // Write data
    output logic [3:0] s_axi_wstrb, // Strobes
    output logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // B valid
    output logic s_axi_bready, // B ready
    output logic [7:0] s_axi_araddr, // Read address
    output logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // R valid
    output logic s_axi_rready // R ready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // Lag delays the ready for the answer, so slow hosts are exercised too
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input int lag, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        repeat (lag) @(posedge sys_clk);
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input int lag, output logic [31:0] d,
                      output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat (lag) @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// File: afc_regbank_tb.sv
/* Self-checking bench for the register bank: random and corner writes, read-back, decode.
   Assumes the host model in afc_host and the bank's forced fixed bits. */
module afc_regbank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic clock_source_pin = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, x = 32'h000038AB, d;
    logic [3:0] s_axi_wstrb, s;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    afc_pkg::afc_global_t cfg_global;
    afc_pkg::afc_chan_t [7:0] cfg_chan;
    logic osc_clk_out_en, test_pulse, cfg_illegal, ill;
    logic [7:0] sh [1:12], a;
    int fail_count = 0, num_checks = 0, cyc = 0;
    afc_regbank u_dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_source_pin, .cfg_global, .cfg_chan,
        .osc_clk_out_en, .test_pulse, .cfg_illegal);
    afc_host u_host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial forever #50 sys_clk = ~sys_clk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] nxt(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic ok(logic [7:0] ad);
        return ad[1:0] == 2'h0 && ad[6:2] >= 5'h01 && ad[6:2] <= 5'h0C;
    endfunction
    // Value a register holds once the fixed bits are applied
    function automatic logic [7:0] fixv(logic [4:0] i, logic [7:0] v);
        case (i)
            afc_pkg::IDX_GLOBAL: return (v & ~afc_pkg::FIX_MASK_GLOBAL) | afc_pkg::FIX_VAL_GLOBAL;
            afc_pkg::IDX_TEST: return (v & ~afc_pkg::FIX_MASK_TEST) | afc_pkg::FIX_VAL_TEST;
            afc_pkg::IDX_REF: return (v & ~afc_pkg::FIX_MASK_REF) | afc_pkg::FIX_VAL_REF;
            afc_pkg::IDX_FAULT: return v & ~afc_pkg::FIX_MASK_FAULT;
            default: return v & ~afc_pkg::FIX_MASK_CH;
        endcase
    endfunction
    task automatic rd_chk(input logic [7:0] ad, input int lag);
        logic [31:0] q;
        logic [1:0] rr;
        u_host.rd(ad, lag, q, rr);
        chk(q, ok(ad) ? {24'h0, sh[ad[6:2]]} : 32'h0);
        chk(rr, ok(ad) ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR);
    endtask
    task automatic check_all;
        ill = sh[1][2:0] == 3'h7 || sh[2][1:0] == 2'h2;
        for (int n = 0; n < 8; n++) begin
            chk(cfg_chan[n].channel_power_down, sh[5+n][7]);
            chk(cfg_chan[n].channel_gain_sel, sh[5+n][6:4]);
            chk(cfg_chan[n].channel_input_sel, sh[5+n][2:0]);
            ill |= sh[5+n][6:4] inside {3'h0, 3'h3, 3'h7};
            ill |= sh[5+n][2:0] inside {3'h2, 3'h6, 3'h7};
        end
        chk(cfg_illegal, ill);
        chk(cfg_global.readback_multi, sh[1][6]);
        chk(osc_clk_out_en, sh[1][5] & clock_source_pin);
        chk(cfg_global.clk_out_en, sh[1][5]);
        chk(cfg_global.rate_field, sh[1][2:0]);
        if (sh[1][2:0] != 3'h7) chk(cfg_global.rate_24bit, sh[1][2:0] inside {[3'h2:3'h6]});
        chk(cfg_global.int_test, sh[2][4]);
        chk(cfg_global.test_amp_x2, sh[2][2]);
        chk(cfg_global.test_frequency_sel, sh[2][1:0]);
        if (!sh[2][4] || sh[2][1:0] == 2'h3) chk(test_pulse, sh[2][4]);
        chk(cfg_global.ref_buffer_on, sh[3][7]);
        chk(cfg_global.ref_level_high, sh[3][5]);
        chk(cfg_global.amp_input_route, sh[3][3]);
        chk(cfg_global.amp_power_on, sh[3][2]);
        chk(cfg_global.comparator_threshold_sel, sh[4][7:5]);
    endtask
    initial begin
        for (int i = 5; i <= 12; i++) sh[i] = afc_pkg::RST_CH;
        sh[1] = afc_pkg::RST_GLOBAL;
        sh[2] = afc_pkg::RST_TEST;
        sh[3] = afc_pkg::RST_REF;
        sh[4] = afc_pkg::RST_FAULT;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 16; i++) rd_chk(8'(i * 4), 0);
        check_all();
        for (int i = 0; i < 200; i++) begin
            x = nxt(x);
            a = {1'b0, 5'(x[19:16] % 12 + 1), 2'b00};
            if (i < 24) a = {1'b0, 5'(i % 12 + 1), 2'b00};
            else if (x[3:0] == 4'h0) a = {1'b0, x[30:24]};
            d = (i < 24) ? {32{i[0]}} : x;
            if (i[1]) d[7:0] = fixv(a[6:2], d[7:0]);
            s = (i >= 24 && x[9:8] == 2'h0) ? 4'hE : 4'hF;
            clock_source_pin <= x[11];
            u_host.wr(a, d, s, int'(x[13:12]), r);
            chk(r, ok(a) ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR);
            if (ok(a) && s[0]) sh[a[6:2]] = fixv(a[6:2], d[7:0]);
            rd_chk(a, int'(x[15:14]));
            check_all();
        end
        test_done();
    end
endmodule
